// ### rtl/eqc_regs.vh
/*
 * Constants of the error queue classifier: register offsets, queue
 * geometry, status bit positions and the signed 16-bit error codes.
 * Assumes an includer that uses these names as plain `define macros.
 */
`ifndef EQC_REGS_VH
`define EQC_REGS_VH

// Register offsets on the 3-bit register port.
`define EQC_ADDR_W 3
`define EQC_OFS_POP 3'h0
`define EQC_OFS_COUNT 3'h1
`define EQC_OFS_EVT_STATUS 3'h2
`define EQC_OFS_STATUS_CLEAR 3'h3
`define EQC_OFS_LIMIT_LO 3'h4
`define EQC_OFS_LIMIT_HI 3'h5

// Queue geometry: entry width, depth, pointer and count widths.
`define EQC_DATA_W 16
`define EQC_DEPTH 8
`define EQC_PTR_W 3
`define EQC_CNT_W 4

// Event status bit positions.
`define EQC_ESR_W 8
`define EQC_ESR_QUERY 2
`define EQC_ESR_DEVICE 3
`define EQC_ESR_EXEC 4
`define EQC_ESR_CMD 5

// Reset values.
`define EQC_RST_ESR 8'h00
`define EQC_RST_LIMIT_LO 16'h8000
`define EQC_RST_LIMIT_HI 16'h7FFF

// Special codes: no error and queue overflow (-350).
`define EQC_CODE_NONE 16'h0000
`define EQC_CODE_OVERFLOW 16'hFEA2

// Parser codes: -100 -102 -108 -109 -110 -113 -121 -140 -150 -151.
`define EQC_SYN_N 10
`define EQC_CODE_CMD 16'hFF9C
`define EQC_CODE_SYNTAX 16'hFF9A
`define EQC_CODE_PARM_EXTRA 16'hFF94
`define EQC_CODE_PARM_MISS 16'hFF93
`define EQC_CODE_HDR 16'hFF92
`define EQC_CODE_HDR_UNDEF 16'hFF8F
`define EQC_CODE_NUM_CHAR 16'hFF87
`define EQC_CODE_CHAR_DATA 16'hFF74
`define EQC_CODE_STR_DATA 16'hFF6A
`define EQC_CODE_STR_BAD 16'hFF69

// Execution codes: -200 -203 -220, and -222 for a value out of range.
`define EQC_EXE_N 3
`define EQC_CODE_EXEC 16'hFF38
`define EQC_CODE_PROTECTED 16'hFF35
`define EQC_CODE_PARAM 16'hFF24
`define EQC_CODE_RANGE 16'hFF22

// Class bounds: -199 -100, -299 -200, -399 -300, -499 -400.
`define EQC_CMD_LO 16'hFF39
`define EQC_CMD_HI 16'hFF9C
`define EQC_EXE_LO 16'hFED5
`define EQC_EXE_HI 16'hFF38
`define EQC_DEV_LO 16'hFE71
`define EQC_DEV_HI 16'hFED4
`define EQC_QRY_LO 16'hFE0D
`define EQC_QRY_HI 16'hFE70

`endif

// ### rtl/eqc_error_queue.v
/*
 * Error queue with event classification. Error sources push signed
 * 16-bit codes into a first-in first-out queue; the host pops them
 * over a plain register port and reads the event status bits.
 * Assumes all inputs come from logic on i_mclk, so none is
 * synchronised, and that the master never strobes read and write at
 * once.
 */
// The register addresses and the strobed register port were decided locally.
`timescale 1ns/10ps
`include "eqc_regs.vh"

// Behaviour
// - Detected codes queued, read back in order.
// - Full queue: newest entry becomes -350.
// - Empty queue read returns 0.
// - Clear-status command empties queue at once, keeping only a code pushed in that same cycle.
// - Reading last entry leaves queue cleared.
// - Codes -199..-100 set status bit 5.
// - Codes -299..-200 set status bit 4.
// - Range check uses final, rounded value.
// - Parser queues -100 and -102.
// - Parser queues -108 and -109.
// - Parser queues -110 and -113.
// - Parser queues -121 for bad numeric character.
// - Parser queues -140, -150 and -151.
// - Execution queues -200 and -203.
// - Execution queues -220 for data element fault.
// - Device-specific codes set status bit 3.
// - Codes -499..-400 set status bit 2.
module eqc_error_queue (
    input wire i_mclk,
    input wire i_rst_b,
    input wire [`EQC_ADDR_W-1:0] i_addr,
    input wire [`EQC_DATA_W-1:0] i_wdata,
    input wire i_wr,
    input wire i_rd,
    output reg [`EQC_DATA_W-1:0] o_rdata,
    input wire i_cls,
    input wire [`EQC_SYN_N-1:0] i_syn_evt,
    input wire [`EQC_EXE_N-1:0] i_exe_evt,
    input wire i_dev_valid,
    input wire [`EQC_DATA_W-1:0] i_dev_code,
    input wire i_chk_valid,
    input wire [`EQC_DATA_W-1:0] i_chk_value,
    output wire [`EQC_CNT_W-1:0] o_count,
    output wire o_empty,
    output wire [`EQC_ESR_W-1:0] o_esr
);

    localparam DEPTH = `EQC_DEPTH;
    localparam [31:0] DEPTH_W = `EQC_DEPTH;
    localparam [31:0] LAST_W = `EQC_DEPTH - 1;
    localparam [`EQC_CNT_W-1:0] FULL_CNT = DEPTH_W[`EQC_CNT_W-1:0];
    localparam [`EQC_PTR_W-1:0] LAST_PTR = LAST_W[`EQC_PTR_W-1:0];

    ////////////////////////////////////////////////////////////////////

    // Parser event index to code.
    function [`EQC_DATA_W-1:0] syn_code;
        input [3:0] idx;
        begin
            case (idx)
                4'h0: syn_code = `EQC_CODE_CMD;
                4'h1: syn_code = `EQC_CODE_SYNTAX;
                4'h2: syn_code = `EQC_CODE_PARM_EXTRA;
                4'h3: syn_code = `EQC_CODE_PARM_MISS;
                4'h4: syn_code = `EQC_CODE_HDR;
                4'h5: syn_code = `EQC_CODE_HDR_UNDEF;
                4'h6: syn_code = `EQC_CODE_NUM_CHAR;
                4'h7: syn_code = `EQC_CODE_CHAR_DATA;
                4'h8: syn_code = `EQC_CODE_STR_DATA;
                4'h9: syn_code = `EQC_CODE_STR_BAD;
                default: syn_code = `EQC_CODE_CMD;
            endcase
        end
    endfunction

    // Execution event index to code.
    function [`EQC_DATA_W-1:0] exe_code;
        input [1:0] idx;
        begin
            case (idx)
                2'h0: exe_code = `EQC_CODE_EXEC;
                2'h1: exe_code = `EQC_CODE_PROTECTED;
                2'h2: exe_code = `EQC_CODE_PARAM;
                default: exe_code = `EQC_CODE_EXEC;
            endcase
        end
    endfunction

    // Signed inclusive range test, used by every class decode.
    function in_range;
        input [`EQC_DATA_W-1:0] code;
        input [`EQC_DATA_W-1:0] lo;
        input [`EQC_DATA_W-1:0] hi;
        begin
            in_range = ($signed(code) >= $signed(lo)) && ($signed(code) <= $signed(hi));
        end
    endfunction

    // Status bits that a stored code raises.
    function [`EQC_ESR_W-1:0] esr_class;
        input [`EQC_DATA_W-1:0] code;
        begin
            esr_class = `EQC_RST_ESR;
            esr_class[`EQC_ESR_CMD] = in_range(code, `EQC_CMD_LO, `EQC_CMD_HI);
            esr_class[`EQC_ESR_EXEC] = in_range(code, `EQC_EXE_LO, `EQC_EXE_HI);
            esr_class[`EQC_ESR_DEVICE] = in_range(code, `EQC_DEV_LO, `EQC_DEV_HI)
                || ($signed(code) > $signed(`EQC_CODE_NONE));
            esr_class[`EQC_ESR_QUERY] = in_range(code, `EQC_QRY_LO, `EQC_QRY_HI);
        end
    endfunction

    // Pointer step with wrap, so the depth need not be a power of two.
    function [`EQC_PTR_W-1:0] ptr_inc;
        input [`EQC_PTR_W-1:0] p;
        begin
            ptr_inc = (p == LAST_PTR) ? {`EQC_PTR_W{1'b0}} : p + 1'b1;
        end
    endfunction

    function [`EQC_PTR_W-1:0] ptr_dec;
        input [`EQC_PTR_W-1:0] p;
        begin
            ptr_dec = (p == {`EQC_PTR_W{1'b0}}) ? LAST_PTR : p - 1'b1;
        end
    endfunction

    ////////////////////////////////////////////////////////////////////

    reg [`EQC_DATA_W-1:0] mem [0:DEPTH-1];
    reg [`EQC_PTR_W-1:0] wr_ptr;
    reg [`EQC_PTR_W-1:0] rd_ptr;
    reg [`EQC_CNT_W-1:0] count;
    reg [`EQC_ESR_W-1:0] esr;
    reg [`EQC_DATA_W-1:0] limit_lo;
    reg [`EQC_DATA_W-1:0] limit_hi;
    reg [`EQC_DATA_W-1:0] next_code;
    reg next_push;
    reg [3:0] syn_sel;
    reg [1:0] exe_sel;
    reg range_fault;
    integer k;

    wire queue_empty = (count == {`EQC_CNT_W{1'b0}});
    wire pop = i_rd && (i_addr == `EQC_OFS_POP) && !queue_empty;
    wire clear = i_cls || (i_wr && (i_addr == `EQC_OFS_STATUS_CLEAR));
    wire esr_read = i_rd && (i_addr == `EQC_OFS_EVT_STATUS);
    // A pop or a clear in the same cycle frees a slot, so a full queue still takes the code.
    wire store_new = next_push && ((count != FULL_CNT) || pop || clear);
    wire overflow = next_push && !store_new;

    assign o_count = count;
    assign o_empty = queue_empty;
    assign o_esr = esr;

    // final value check
    // The value arrives already rounded and evaluated; only the bounds are checked here.
    always @* begin
        range_fault = i_chk_valid
            && !in_range(i_chk_value, limit_lo, limit_hi);
    end

    // Lowest event index wins; scanning downward leaves it selected last.
    always @* begin
        syn_sel = 4'h0;
        exe_sel = 2'h0;
        for (k = `EQC_SYN_N - 1; k >= 0; k = k - 1) begin
            if (i_syn_evt[k]) begin
                syn_sel = k[3:0];
            end
        end
        for (k = `EQC_EXE_N - 1; k >= 0; k = k - 1) begin
            if (i_exe_evt[k]) begin
                exe_sel = k[1:0];
            end
        end
    end

    // One code per cycle: device input, then parser, then execution, then range check.
    // Lower sources in the same cycle are dropped, so sources must not collide.
    always @* begin
        next_push = 1'b1;
        next_code = `EQC_CODE_NONE;
        if (i_dev_valid) begin
            next_code = i_dev_code;
        end else if (|i_syn_evt) begin
            next_code = syn_code(syn_sel);
        end else if (|i_exe_evt) begin
            next_code = exe_code(exe_sel);
        end else if (range_fault) begin
            next_code = `EQC_CODE_RANGE;
        end else begin
            next_push = 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////

    // Entry storage has no reset; reads of unwritten slots are masked by the count.
    always @(posedge i_mclk) begin
        if (clear) begin
            if (next_push) begin
                mem[0] <= next_code;
            end
        end else if (store_new) begin
            mem[wr_ptr] <= next_code;
        end else if (overflow) begin
            mem[ptr_dec(wr_ptr)] <= `EQC_CODE_OVERFLOW;
        end
    end

    // Pointers and fill count. A clear keeps a code that lands in its own cycle.
    always @(posedge i_mclk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            wr_ptr <= {`EQC_PTR_W{1'b0}};
            rd_ptr <= {`EQC_PTR_W{1'b0}};
            count <= {`EQC_CNT_W{1'b0}};
        end else if (clear) begin
            rd_ptr <= {`EQC_PTR_W{1'b0}};
            wr_ptr <= next_push ? ptr_inc({`EQC_PTR_W{1'b0}}) : {`EQC_PTR_W{1'b0}};
            count <= next_push ? {{(`EQC_CNT_W-1){1'b0}}, 1'b1} : {`EQC_CNT_W{1'b0}};
        end else if (pop && (count == {{(`EQC_CNT_W-1){1'b0}}, 1'b1}) && !store_new) begin
            rd_ptr <= {`EQC_PTR_W{1'b0}};
            wr_ptr <= {`EQC_PTR_W{1'b0}};
            count <= {`EQC_CNT_W{1'b0}};
        end else begin
            if (store_new) begin
                wr_ptr <= ptr_inc(wr_ptr);
            end
            if (pop) begin
                rd_ptr <= ptr_inc(rd_ptr);
            end
            if (store_new && !pop) begin
                count <= count + 1'b1;
            end else if (pop && !store_new) begin
                count <= count - 1'b1;
            end
        end
    end

    // Event status: cleared by reading it or by clear-status, but a class
    // raised in that same cycle still lands so no error goes unreported.
    always @(posedge i_mclk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            esr <= `EQC_RST_ESR;
        end else begin
            esr <= ((clear || esr_read) ? `EQC_RST_ESR : esr)
                | (store_new ? esr_class(next_code) : `EQC_RST_ESR)
                | (overflow ? esr_class(`EQC_CODE_OVERFLOW) : `EQC_RST_ESR);
        end
    end

    // Software range limits for the execution value check.
    always @(posedge i_mclk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            limit_lo <= `EQC_RST_LIMIT_LO;
            limit_hi <= `EQC_RST_LIMIT_HI;
        end else if (i_wr) begin
            if (i_addr == `EQC_OFS_LIMIT_LO) begin
                limit_lo <= i_wdata;
            end
            if (i_addr == `EQC_OFS_LIMIT_HI) begin
                limit_hi <= i_wdata;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////

    // Read data stand for the one cycle after the strobe, zero otherwise.
    always @(posedge i_mclk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            o_rdata <= `EQC_CODE_NONE;
        end else if (i_rd) begin
            case (i_addr)
                `EQC_OFS_POP: begin
                    o_rdata <= queue_empty ? `EQC_CODE_NONE : mem[rd_ptr];
                end
                `EQC_OFS_COUNT: begin
                    o_rdata <= {{(`EQC_DATA_W-`EQC_CNT_W){1'b0}}, count};
                end
                `EQC_OFS_EVT_STATUS: begin
                    o_rdata <= {{(`EQC_DATA_W-`EQC_ESR_W){1'b0}}, esr};
                end
                `EQC_OFS_LIMIT_LO: begin
                    o_rdata <= limit_lo;
                end
                `EQC_OFS_LIMIT_HI: begin
                    o_rdata <= limit_hi;
                end
                default: begin
                    o_rdata <= `EQC_CODE_NONE;
                end
            endcase
        end else begin
            o_rdata <= `EQC_CODE_NONE;
        end
    end

endmodule

// ### tb/eqc_queue_monitor.sv
/* Checker for the ports of the error queue.
   Assumes the bind below and the shared constants header. */
`timescale 1ns/10ps
`include "eqc_regs.vh"
module eqc_queue_monitor (
    input wire i_mclk,
    input wire i_rst_b,
    input wire [`EQC_ADDR_W-1:0] i_addr,
    input wire i_rd,
    input wire i_wr,
    input wire i_cls,
    input wire [`EQC_SYN_N-1:0] i_syn_evt,
    input wire [`EQC_EXE_N-1:0] i_exe_evt,
    input wire i_dev_valid,
    input wire i_chk_valid,
    input wire [`EQC_DATA_W-1:0] o_rdata,
    input wire [`EQC_CNT_W-1:0] o_count,
    input wire o_empty,
    input wire [`EQC_ESR_W-1:0] o_esr
);
    // Push and pop as seen at the port; range checks may or may not push.
    wire push = i_dev_valid || (|i_syn_evt) || (|i_exe_evt);
    wire pop = i_rd && (i_addr == `EQC_OFS_POP);
    // A write to the clear register empties the queue just as the command does.
    wire clr_any = i_cls || (i_wr && (i_addr == `EQC_OFS_STATUS_CLEAR));
    // A full queue with no pop and no clear overflows instead of storing.
    wire room = (o_count < `EQC_DEPTH) || pop || clr_any;
    default clocking @(posedge i_mclk); endclocking
    default disable iff (!i_rst_b);
    ////////////////////////////////////////////////////////////////////////
    chk_empty_flag: assert property (o_empty == (o_count == 0))
        else $error("empty flag disagrees with count");
    chk_rdata_idle: assert property (!i_rd |=> o_rdata == 0)
        else $error("read data not idle");
    chk_empty_read: assert property ((pop && o_empty && !push && !i_chk_valid && !clr_any)
        |=> (o_rdata == 0 && o_empty))
        else $error("empty pop not zero");
    chk_push_grow: assert property ((push && !pop && !clr_any && o_count < `EQC_DEPTH)
        |=> o_count == $past(o_count) + 1)
        else $error("push did not add one entry");
    chk_pop_shrink: assert property ((pop && !push && !i_chk_valid && !clr_any && !o_empty)
        |=> o_count == $past(o_count) - 1)
        else $error("pop did not remove one entry");
    chk_full_stay: assert property ((push && !pop && !clr_any && o_count == `EQC_DEPTH)
        |=> (o_count == `EQC_DEPTH && o_esr[`EQC_ESR_DEVICE]))
        else $error("overflow mishandled");
    chk_clear_all: assert property ((i_cls && !push && !i_chk_valid)
        |=> (o_empty && o_esr == 0))
        else $error("clear status left state");
    chk_cmd_bit: assert property (((|i_syn_evt) && !i_dev_valid && room) |=> o_esr[5])
        else $error("command class bit missing");
    chk_exec_bit: assert property (((|i_exe_evt) && !i_dev_valid && i_syn_evt == 0 && room)
        |=> o_esr[4])
        else $error("execution class bit missing");
endmodule
bind eqc_error_queue eqc_queue_monitor u_mon (.i_mclk(i_mclk), .i_rst_b(i_rst_b),
    .i_addr(i_addr), .i_rd(i_rd), .i_wr(i_wr), .i_cls(i_cls), .i_syn_evt(i_syn_evt),
    .i_exe_evt(i_exe_evt), .i_dev_valid(i_dev_valid), .i_chk_valid(i_chk_valid),
    .o_rdata(o_rdata), .o_count(o_count), .o_empty(o_empty), .o_esr(o_esr));

// ### tb/eqc_parser_model.sv
/* Far-side model: command parser and execution control as error sources.
   Assumes one request strobe a push, driven just after a clock edge. */
`timescale 1ns/10ps
`include "eqc_regs.vh"
module eqc_parser_model (
    input wire i_req,
    input wire [1:0] i_kind,
    input wire [3:0] i_idx,
    input wire [`EQC_DATA_W-1:0] i_code,
    input wire i_clr,
    output wire o_cls,
    output wire [`EQC_SYN_N-1:0] o_syn_evt,
    output wire [`EQC_EXE_N-1:0] o_exe_evt,
    output wire o_dev_valid,
    output wire [`EQC_DATA_W-1:0] o_dev_code,
    output wire o_chk_valid,
    output wire [`EQC_DATA_W-1:0] o_chk_value
);
    assign o_cls = i_clr;
    assign o_syn_evt = (i_req && i_kind == 2'h1) ? (10'h001 << i_idx) : 10'h000;
    assign o_exe_evt = (i_req && i_kind == 2'h2) ? (3'h1 << i_idx) : 3'h0;
    // raw codes; idle data shows the inverse so stale values never pass.
    assign o_dev_valid = i_req && i_kind == 2'h0;
    assign o_dev_code = o_dev_valid ? i_code : ~i_code;
    assign o_chk_valid = i_req && i_kind == 2'h3;
    assign o_chk_value = o_chk_valid ? i_code : ~i_code;
endmodule

// ### tb/error_queue_classifier_test.sv
/* Self-checking bench for the error queue.
   Assumes the parser model drives the error sources and the bind attaches the checker. */
`timescale 1ns/10ps
`include "eqc_regs.vh"
module error_queue_classifier_test;
    reg i_mclk = 1'b0;
    reg i_rst_b = 1'b0;
    reg [2:0] i_addr = 3'h0;
    reg [15:0] i_wdata = 16'h0000;
    reg i_wr = 1'b0;
    reg i_rd = 1'b0;
    reg req = 1'b0;
    reg clr = 1'b0;
    reg [1:0] kind = 2'h0;
    reg [3:0] idx = 4'h0;
    reg [15:0] code = 16'h0000;
    reg rd_d = 1'b0;
    reg [7:0] esr_ref = 8'h00;
    wire cls, dev_v, chk_v, empty;
    wire [9:0] syn;
    wire [2:0] exe;
    wire [15:0] dev_c, chk_c, rdata;
    wire [3:0] count;
    wire [7:0] esr;
    logic [15:0] exp_q[$];
    logic [15:0] ref_q[$];
    int error_cnt = 0;
    int num_checks = 0;
    int syn_tab[10] = '{-100, -102, -108, -109, -110, -113, -121, -140, -150, -151};
    int exe_tab[3] = '{-200, -203, -220};
    eqc_parser_model u_model (.i_req(req), .i_kind(kind), .i_idx(idx), .i_code(code),
        .i_clr(clr), .o_cls(cls), .o_syn_evt(syn), .o_exe_evt(exe), .o_dev_valid(dev_v),
        .o_dev_code(dev_c), .o_chk_valid(chk_v), .o_chk_value(chk_c));
    eqc_error_queue DUT (.i_mclk(i_mclk), .i_rst_b(i_rst_b), .i_addr(i_addr),
        .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .o_rdata(rdata), .i_cls(cls),
        .i_syn_evt(syn), .i_exe_evt(exe), .i_dev_valid(dev_v), .i_dev_code(dev_c),
        .i_chk_valid(chk_v), .i_chk_value(chk_c), .o_count(count), .o_empty(empty),
        .o_esr(esr));
    // Clock of 100 ns.
    always #50 i_mclk = ~i_mclk;
    ////////////////////////////////////////////////////////////////////////
    task automatic check(input logic [15:0] seen, input logic [15:0] want);
        num_checks++;
        if (seen !== want) begin
            error_cnt++;
            $display("ERROR %0t: saw %h expected %h", $time, seen, want);
        end
    endtask
    task automatic wrap_up;
        if (error_cnt == 0 && num_checks > 0) $display("Simulation passed");
        else $display("Simulation failed");
        $finish;
    endtask
    // Status class of a code, worked out independently of the design.
    function automatic [7:0] cls_bit(input int c);
        cls_bit = 8'h00;
        if (c >= -199 && c <= -100) cls_bit = 8'h20;
        else if (c >= -299 && c <= -200) cls_bit = 8'h10;
        else if ((c >= -399 && c <= -300) || c > 0) cls_bit = 8'h08;
        else if (c >= -499 && c <= -400) cls_bit = 8'h04;
    endfunction
    task automatic rd(input logic [2:0] a, input logic [15:0] want);
        @(posedge i_mclk);
        i_rd <= 1'b1;
        i_addr <= a;
        exp_q.push_back(want);
        @(posedge i_mclk);
        i_rd <= 1'b0;
    endtask
    task automatic wr(input logic [2:0] a, input logic [15:0] d);
        @(posedge i_mclk);
        i_wr <= 1'b1;
        i_addr <= a;
        i_wdata <= d;
        @(posedge i_mclk);
        i_wr <= 1'b0;
    endtask
    task automatic pop;
        rd(3'h0, ref_q.size() > 0 ? ref_q.pop_front() : 16'h0000);
    endtask
    // Reference queue follows every push; a full queue swaps its newest entry.
    task automatic push(input int k, input int i, input logic [15:0] c, input bit keep);
        logic [15:0] v;
        v = (k == 0) ? c : (k == 1) ? 16'(syn_tab[i]) : (k == 2) ? 16'(exe_tab[i]) : 16'hFF22;
        @(posedge i_mclk);
        req <= 1'b1;
        kind <= k[1:0];
        idx <= i[3:0];
        code <= c;
        @(posedge i_mclk);
        req <= 1'b0;
        if (keep && ref_q.size() < 8) ref_q.push_back(v);
        else if (keep) ref_q[7] = 16'(-350);
        if (keep) esr_ref |= (ref_q.size() == 8 && ref_q[7] == 16'(-350))
            ? 8'h08 : cls_bit(int'($signed(v)));
    endtask
    task automatic esr_rd;
        rd(3'h2, {8'h00, esr_ref});
        esr_ref = 8'h00;
    endtask
    // Scoreboard: each read result is compared with the oldest note.
    always @(posedge i_mclk) rd_d <= i_rd;
    always @(negedge i_mclk) if (rd_d) check(rdata, exp_q.pop_front());
    initial begin
        repeat (5000) @(posedge i_mclk);
        error_cnt++;
        wrap_up();
    end
    initial begin
        void'($urandom(26747));
        repeat (8) @(posedge i_mclk);
        check({esr, 3'h0, empty, count}, 16'h0010);
        i_rst_b <= 1'b1;
        rd(3'h1, 16'h0000);
        pop();
        rd(3'h4, 16'h8000);
        rd(3'h5, 16'h7FFF);
        rd(3'h6, 16'h0000);
        for (int i = 0; i < 10; i++) push(1, i, 16'h0000, 1);
        esr_rd();
        esr_rd();
        repeat (9) pop();
        for (int i = 0; i < 3; i++) push(2, i, 16'h0000, 1);
        repeat (3) push(0, 0, 16'($urandom), 1);
        push(0, 0, 16'(-450), 1);
        push(0, 0, 16'h0005, 1);
        rd(3'h1, 16'h0008);
        esr_rd();
        repeat (8) pop();
        wr(3'h5, 16'h0064);
        push(3, 0, 16'h0065, 1);
        push(3, 0, 16'h0064, 0);
        wr(3'h4, 16'hFF9C);
        push(3, 0, 16'hFF9B, 1);
        rd(3'h1, 16'h0002);
        repeat (2) pop();
        esr_rd();
        push(1, 4, 16'h0000, 1);
        push(0, 0, 16'h0007, 1);
        @(posedge i_mclk);
        clr <= 1'b1;
        @(posedge i_mclk);
        clr <= 1'b0;
        ref_q.delete();
        esr_ref = 8'h00;
        rd(3'h1, 16'h0000);
        esr_rd();
        push(2, 1, 16'h0000, 1);
        wr(3'h3, 16'h0000);
        ref_q.delete();
        esr_ref = 8'h00;
        pop();
        esr_rd();
        // Full queue: a pop beside a push frees the slot, so the new code is stored.
        for (int i = 0; i < 8; i++) push(2, 0, 16'h0000, 1);
        @(posedge i_mclk);
        i_rd <= 1'b1;
        i_addr <= 3'h0;
        req <= 1'b1;
        kind <= 2'h0;
        code <= 16'h0009;
        exp_q.push_back(ref_q.pop_front());
        ref_q.push_back(16'h0009);
        esr_ref |= 8'h08;
        @(posedge i_mclk);
        i_rd <= 1'b0;
        req <= 1'b0;
        rd(3'h1, 16'h0008);
        esr_rd();
        // A clear beside a push on a full queue keeps only the new code and its class.
        @(posedge i_mclk);
        clr <= 1'b1;
        req <= 1'b1;
        kind <= 2'h1;
        idx <= 4'h2;
        @(posedge i_mclk);
        clr <= 1'b0;
        req <= 1'b0;
        ref_q.delete();
        ref_q.push_back(16'hFF94);
        esr_ref = 8'h20;
        rd(3'h1, 16'h0001);
        esr_rd();
        repeat (2) pop();
        repeat (3) @(posedge i_mclk);
        wrap_up();
    end
endmodule
